// File: inc/ptlb_pkg.sv
/*
  Constants for the PHY test, loopback and self-test block.
  Assumes a 125 MHz system clock and decoded management accesses.
*/
`default_nettype none
package ptlb_pkg;
  // Management register offsets
  localparam logic [4:0] A_BASIC = 5'h00;
  localparam logic [4:0] A_MMD_CTL = 5'h0d;
  localparam logic [4:0] A_MMD_DAT = 5'h0e;
  localparam logic [4:0] A_STC = 5'h16;
  localparam logic [4:0] A_GAP = 5'h1b;
  localparam logic [4:0] A_LEN = 5'h1c;
  // Extended spaces and registers
  localparam logic [4:0] SP_PMA = 5'h01;
  localparam logic [4:0] SP_VEND = 5'h1f;
  localparam logic [15:0] X_TEST = 16'h0836;
  localparam logic [15:0] X_IND = 16'h0462;
  localparam logic [15:0] X_STRAP = 16'h0467;
  localparam logic [1:0] FN_ADDR = 2'h0;
  localparam logic [1:0] FN_DATA = 2'h1;
  localparam logic [15:0] IND_TCLK = 16'h0011;
  // Field positions
  localparam int B_MLOOP = 14;
  localparam int B_ISO = 10;
  localparam int B_GEN = 13;
  localparam int B_CHK = 12;
  localparam int B_DIG = 2;
  localparam int B_PCS = 1;
  localparam int B_REV = 4;
  localparam int ST_LO = 9;
  localparam int ST_HI = 11;
  localparam int TM_LO = 13;
  localparam int B_ESEL = 15;
  localparam logic [15:0] STC_RO = 16'h0e00;
  // Reset values
  localparam logic [15:0] BASIC_RST = 16'h0000;
  localparam logic [15:0] STC_RST = 16'h0000;
  localparam logic [7:0] GAP_RST = 8'h7d;
  localparam logic [10:0] LEN_RST = 11'h5ee;
  localparam logic [10:0] LFSR_SEED = 11'h7ff;
  // Test mode codes
  localparam logic [2:0] TM_OFF = 3'h0;
  localparam logic [2:0] TM1 = 3'h1;
  localparam logic [2:0] TM2 = 3'h2;
  localparam logic [2:0] TM4 = 3'h4;
  localparam logic [2:0] TM5 = 3'h5;
  localparam logic [6:0] TM1_RUN = 7'h28;
  // Line symbols
  localparam logic [1:0] SYM_P = 2'h1;
  localparam logic [1:0] SYM_Z = 2'h0;
  localparam logic [1:0] SYM_M = 2'h3;
  // Symbol clock synthesis, rates in kHz
  localparam longint unsigned SYS_KHZ = 125000;
  localparam longint unsigned SYM_KHZ = 66667;
  localparam logic [31:0] NCO_INC =
    32'((SYM_KHZ * 64'h1_0000_0000) / SYS_KHZ);
  typedef enum logic [1:0] {GEN_IDLE, GEN_PKT, GEN_GAP} ptlb_gen_t;
endpackage
`default_nettype wire

// File: core/ptlb_core.sv
/*
  PHY test, loopback and self-test logic, one clock domain.
  Assumes management accesses arrive already decoded from the serial
  management frame as one-cycle strobes; line data is byte wide.
*/
// How it works
// [RULE1] Mode 2 sends continuous tone at symbol rate
// [RULE2] Symbol clock synthesised at 66.667 MHz nominal
// [RULE3] Upper test register bits select modes 1,2,4,5
// [RULE4] Indirect access: space, address, space+0x4000, data
// [RULE5] Value 0x0011 routes symbol clock to indicator
// [RULE6] Basic control bit 14 loops MAC transmit back
// [RULE7] Reverse loop returns line receive to line
// [RULE8] Self-test control bit 4 enables reverse loop
// [RULE9] MAC receive continues; isolate bit 10 suppresses
// [RULE10] Gap field counts four-byte units
// [RULE11] Length field gives packet bytes
// [RULE12] 0x7100 starts generator and checker
// [RULE13] Status bits 11:9 always readable
// [RULE14] Select bit 15 shows error count high
// [RULE15] Self-test runs with any loopback path; with only the reverse loop set, the generator bytes never reach the checker
// [RULE16] Four loopback paths, each independently selectable; code picks one near-end path, MAC loop over PCS over digital
// [RULE17] Straps captured after reset, readable at 0x467
// [RULE18] Mode 1 sends forty plus, forty minus
// [RULE19] Mode zero restores normal operation live
`timescale 1ns/100ps
`default_nettype none
module ptlb_core #(
  parameter int STRAP_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  input wire logic [7:0] mac_tx_data,
  input wire logic mac_tx_valid,
  output logic [7:0] mac_rx_data,
  output logic mac_rx_valid,
  input wire logic [7:0] line_rx_data,
  input wire logic line_rx_valid,
  output logic [7:0] line_tx_data,
  output logic line_tx_valid,
  output logic [1:0] line_test_sym,
  output logic line_test_active,
  output logic transmit_symbol_clock,
  output logic indicator_pin_one,
  input wire logic [STRAP_W-1:0] strap_pins
);
  logic [15:0] basic_q, basic_d, stc_q, stc_d, mctl_q, mctl_d;
  logic [15:0] maddr_q, maddr_d, tst_q, tst_d, ind_q, ind_d;
  logic [15:0] rd_q, rd_d, rv;
  logic [7:0] gap_q, gap_d, err_q, err_d, exp_q, exp_d;
  logic [10:0] len_q, len_d, lfsr_q, lfsr_d;
  logic esel_q, esel_d, seen_q, seen_d;
  logic [2:0] tm, status;
  logic tm_act, gen_on, loop_any, tx_v, rx_v, lp_v;
  logic [7:0] tx_b, rx_b, lp_b;
  logic [7:0] d1_b, d2_b, mrx_b, ltx_b;
  logic d1_v, d2_v, mrx_v, ltx_v;
  logic [7:0] d1_bd, d2_bd, mrx_bd, ltx_bd;
  logic d1_vd, d2_vd, mrx_vd, ltx_vd;
  ptlb_pkg::ptlb_gen_t gen_q, gen_d;
  logic [12:0] cnt_q, cnt_d;
  logic [31:0] acc_q, acc_d;
  logic stb_q, stb_d, sclk_q, sclk_d;
  logic [6:0] run_q, run_d;
  logic [1:0] sym_q, sym_d;
  logic tact_q, tact_d;
  logic [STRAP_W-1:0] s1_q, s2_q, s3_q, strap_q, strap_d;
  logic sdone_q, sdone_d;
  logic [2:0] fill_q, fill_d;

  assign tm = tst_q[15:ptlb_pkg::TM_LO];
  assign tm_act = (tm == ptlb_pkg::TM1) || (tm == ptlb_pkg::TM2) ||
                  (tm == ptlb_pkg::TM4) || (tm == ptlb_pkg::TM5); // [RULE3]
  assign gen_on = stc_q[ptlb_pkg::B_GEN]; // [RULE12]
  assign status = {err_q != 8'h00, seen_q, gen_q == ptlb_pkg::GEN_PKT};

  // Register writes and the registered read port
  always_comb begin
    basic_d = basic_q;
    stc_d = stc_q;
    gap_d = gap_q;
    len_d = len_q;
    mctl_d = mctl_q;
    maddr_d = maddr_q;
    tst_d = tst_q;
    ind_d = ind_q;
    esel_d = esel_q;
    rv = 16'h0000;
    if (mgmt_addr == ptlb_pkg::A_BASIC) begin
      rv = basic_q;
    end else if (mgmt_addr == ptlb_pkg::A_STC) begin
      rv = (stc_q & ~ptlb_pkg::STC_RO) |
           {4'h0, status, 9'h000}; // [RULE13]
    end else if (mgmt_addr == ptlb_pkg::A_GAP) begin
      rv = {esel_q ? err_q : 8'h00, gap_q}; // [RULE14]
    end else if (mgmt_addr == ptlb_pkg::A_LEN) begin
      rv = {5'h00, len_q};
    end else if (mgmt_addr == ptlb_pkg::A_MMD_CTL) begin
      rv = mctl_q;
    end else if (mgmt_addr == ptlb_pkg::A_MMD_DAT) begin
      rv = maddr_q;
      if (mctl_q[15:14] == ptlb_pkg::FN_DATA) begin // [RULE4]
        rv = 16'h0000;
        if (mctl_q[4:0] == ptlb_pkg::SP_PMA &&
            maddr_q == ptlb_pkg::X_TEST) begin
          rv = tst_q;
        end else if (mctl_q[4:0] == ptlb_pkg::SP_VEND &&
                     maddr_q == ptlb_pkg::X_IND) begin
          rv = ind_q;
        end else if (mctl_q[4:0] == ptlb_pkg::SP_VEND &&
                     maddr_q == ptlb_pkg::X_STRAP) begin
          rv = 16'(strap_q); // [RULE17]
        end
      end
    end
    rd_d = mgmt_rd ? rv : rd_q;
    if (mgmt_wr) begin
      if (mgmt_addr == ptlb_pkg::A_BASIC) begin
        basic_d = mgmt_wdata; // [RULE6] [RULE9]
      end else if (mgmt_addr == ptlb_pkg::A_STC) begin
        stc_d = mgmt_wdata & ~ptlb_pkg::STC_RO; // [RULE8] [RULE12]
      end else if (mgmt_addr == ptlb_pkg::A_GAP) begin
        gap_d = mgmt_wdata[7:0]; // [RULE10]
        esel_d = mgmt_wdata[ptlb_pkg::B_ESEL]; // [RULE14]
      end else if (mgmt_addr == ptlb_pkg::A_LEN) begin
        len_d = mgmt_wdata[10:0]; // [RULE11]
      end else if (mgmt_addr == ptlb_pkg::A_MMD_CTL) begin
        mctl_d = mgmt_wdata;
      end else if (mgmt_addr == ptlb_pkg::A_MMD_DAT) begin
        // Function 00 loads the address, 01 reaches the data
        if (mctl_q[15:14] == ptlb_pkg::FN_ADDR) begin
          maddr_d = mgmt_wdata; // [RULE4]
        end else if (mctl_q[15:14] == ptlb_pkg::FN_DATA) begin
          if (mctl_q[4:0] == ptlb_pkg::SP_PMA &&
              maddr_q == ptlb_pkg::X_TEST) begin
            tst_d = mgmt_wdata; // [RULE3] [RULE19]
          end else if (mctl_q[4:0] == ptlb_pkg::SP_VEND &&
                       maddr_q == ptlb_pkg::X_IND) begin
            ind_d = mgmt_wdata; // [RULE5]
          end
        end
      end
    end
  end

  // Strap capture: three-stage sync, taken once the last two agree
  always_comb begin
    strap_d = strap_q;
    sdone_d = sdone_q;
    fill_d = {fill_q[1:0], 1'b1};
    // Wait for the chain to fill, or reset zeros get latched
    if (!sdone_q && &fill_q && s2_q == s3_q) begin
      strap_d = s3_q; // [RULE17]
      sdone_d = 1'b1;
    end
  end

  // Loop routing; the later stages model the deeper near-end paths
  always_comb begin
    tx_v = gen_on ? gen_q == ptlb_pkg::GEN_PKT : mac_tx_valid; // [RULE15]
    tx_b = gen_on ? cnt_q[7:0] : mac_tx_data;
    loop_any = basic_q[ptlb_pkg::B_MLOOP] | stc_q[ptlb_pkg::B_PCS] |
               stc_q[ptlb_pkg::B_DIG]; // [RULE16]
    if (basic_q[ptlb_pkg::B_MLOOP]) begin
      lp_v = tx_v; // [RULE6]
      lp_b = tx_b;
    end else if (stc_q[ptlb_pkg::B_PCS]) begin
      lp_v = d1_v;
      lp_b = d1_b;
    end else begin
      lp_v = d2_v;
      lp_b = d2_b;
    end
    rx_v = loop_any ? lp_v : line_rx_valid;
    rx_b = loop_any ? lp_b : line_rx_data;
    d1_vd = tx_v;
    d1_bd = tx_b;
    d2_vd = d1_v;
    d2_bd = d1_b;
    // Reverse loop leaves the MAC view alone; only isolate blanks it
    mrx_vd = rx_v & ~basic_q[ptlb_pkg::B_ISO]; // [RULE9]
    mrx_bd = rx_b;
    if (tm_act) begin
      ltx_vd = 1'b0; // Test patterns own the line
      ltx_bd = 8'h00;
    end else if (stc_q[ptlb_pkg::B_REV]) begin
      ltx_vd = line_rx_valid; // [RULE7] [RULE8]
      ltx_bd = line_rx_data;
    end else begin
      ltx_vd = tx_v & ~loop_any;
      ltx_bd = tx_b;
    end
  end

  // Packet generator and byte-sequence checker
  always_comb begin
    gen_d = gen_q;
    cnt_d = cnt_q + 13'h1;
    err_d = err_q;
    exp_d = 8'h00;
    seen_d = seen_q;
    case (gen_q)
      ptlb_pkg::GEN_IDLE: begin
        cnt_d = 13'h0;
        if (gen_on) gen_d = ptlb_pkg::GEN_PKT;
      end
      ptlb_pkg::GEN_PKT: begin
        if (cnt_q + 13'h1 >= {2'h0, len_q}) begin // [RULE11]
          cnt_d = 13'h0;
          if (gap_q != 8'h00) gen_d = ptlb_pkg::GEN_GAP;
        end
      end
      default: begin
        if (cnt_q + 13'h1 >= {3'h0, gap_q, 2'h0}) begin // [RULE10]
          cnt_d = 13'h0;
          gen_d = ptlb_pkg::GEN_PKT;
        end
      end
    endcase
    if (!gen_on) gen_d = ptlb_pkg::GEN_IDLE;
    // Expected byte restarts at every frame gap
    if (gen_on && stc_q[ptlb_pkg::B_CHK] && rx_v) begin
      seen_d = 1'b1;
      exp_d = exp_q + 8'h1;
      if (rx_b != exp_q && err_q != 8'hff) err_d = err_q + 8'h1;
    end
    if (mgmt_wr && mgmt_addr == ptlb_pkg::A_STC &&
        mgmt_wdata[ptlb_pkg::B_GEN] && !gen_on) begin
      err_d = 8'h00; // Fresh run clears the tally
      seen_d = 1'b0;
    end
  end

  // Symbol clock NCO and compliance patterns
  always_comb begin
    {stb_d, acc_d} = {1'b0, acc_q} + {1'b0, ptlb_pkg::NCO_INC}; // [RULE2]
    sclk_d = acc_d[31];
    run_d = run_q;
    sym_d = sym_q;
    lfsr_d = lfsr_q;
    tact_d = tm_act; // [RULE19]
    if (!tm_act) begin
      sym_d = ptlb_pkg::SYM_Z;
      run_d = 7'h0;
    end else if (stb_q) begin
      lfsr_d = {lfsr_q[9:0], lfsr_q[10] ^ lfsr_q[8]};
      case (tm)
        ptlb_pkg::TM1: begin
          sym_d = (run_q < ptlb_pkg::TM1_RUN) ?
                  ptlb_pkg::SYM_P : ptlb_pkg::SYM_M; // [RULE18]
          run_d = (run_q + 7'h1 >= {ptlb_pkg::TM1_RUN[5:0], 1'b0}) ?
                  7'h0 : run_q + 7'h1;
        end
        ptlb_pkg::TM2: begin
          sym_d = (sym_q == ptlb_pkg::SYM_P) ?
                  ptlb_pkg::SYM_M : ptlb_pkg::SYM_P; // [RULE1]
        end
        ptlb_pkg::TM4: begin
          sym_d = (lfsr_q[1:0] == 2'h2) ? ptlb_pkg::SYM_Z :
                  {lfsr_q[0], 1'b1};
        end
        default: begin
          sym_d = lfsr_q[0] ? ptlb_pkg::SYM_M : ptlb_pkg::SYM_P;
        end
      endcase
    end
  end

  // All state registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      basic_q <= ptlb_pkg::BASIC_RST;
      stc_q <= ptlb_pkg::STC_RST;
      gap_q <= ptlb_pkg::GAP_RST;
      len_q <= ptlb_pkg::LEN_RST;
      {mctl_q, maddr_q, tst_q, ind_q, rd_q} <= '0;
      {esel_q, seen_q, err_q, exp_q, cnt_q} <= '0;
      gen_q <= ptlb_pkg::GEN_IDLE;
      {d1_v, d1_b, d2_v, d2_b, mrx_v, mrx_b, ltx_v, ltx_b} <= '0;
      {acc_q, stb_q, sclk_q, run_q, sym_q, tact_q} <= '0;
      lfsr_q <= ptlb_pkg::LFSR_SEED;
      {s1_q, s2_q, s3_q, strap_q, sdone_q, fill_q} <= '0;
    end else begin
      basic_q <= basic_d;
      stc_q <= stc_d;
      gap_q <= gap_d;
      len_q <= len_d;
      {mctl_q, maddr_q, tst_q, ind_q, rd_q} <=
        {mctl_d, maddr_d, tst_d, ind_d, rd_d};
      {esel_q, seen_q, err_q, exp_q, cnt_q} <=
        {esel_d, seen_d, err_d, exp_d, cnt_d};
      gen_q <= gen_d;
      {d1_v, d1_b, d2_v, d2_b} <= {d1_vd, d1_bd, d2_vd, d2_bd};
      {mrx_v, mrx_b, ltx_v, ltx_b} <= {mrx_vd, mrx_bd, ltx_vd, ltx_bd};
      {acc_q, stb_q, sclk_q, run_q, sym_q, tact_q} <=
        {acc_d, stb_d, sclk_d, run_d, sym_d, tact_d};
      lfsr_q <= lfsr_d;
      {s1_q, s2_q, s3_q} <= {strap_pins, s1_q, s2_q};
      {strap_q, sdone_q, fill_q} <= {strap_d, sdone_d, fill_d};
    end
  end

  assign mgmt_rdata = rd_q;
  assign {mac_rx_valid, mac_rx_data} = {mrx_v, mrx_b};
  assign {line_tx_valid, line_tx_data} = {ltx_v, ltx_b};
  assign line_test_sym = sym_q;
  assign line_test_active = tact_q;
  assign transmit_symbol_clock = sclk_q;
  // Registered sclk_q gated by a combinational compare of ind_q with IND_TCLK
  assign indicator_pin_one = sclk_q & (ind_q == ptlb_pkg::IND_TCLK);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_tone;
    (tact_q && tm == ptlb_pkg::TM2 && stb_q) |=> (sym_q != $past(sym_q));
  endproperty
  a_tone: assert property (p_tone) else $error("tone stalled"); // [RULE1]
  property p_nco;
    stb_q |-> ##[1:2] stb_q;
  endproperty
  a_nco: assert property (p_nco) else $error("symbol rate low"); // [RULE2]
  property p_addr;
    (mgmt_wr && mgmt_addr == ptlb_pkg::A_MMD_DAT &&
     mctl_q[15:14] == ptlb_pkg::FN_ADDR) |=>
      maddr_q == $past(mgmt_wdata);
  endproperty
  a_addr: assert property (p_addr) else $error("addr lost"); // [RULE4]
  property p_tm;
    (tm == ptlb_pkg::TM_OFF) |=> !line_test_active;
  endproperty
  a_tm: assert property (p_tm) else $error("test stuck"); // [RULE19]
  property p_ind;
    (ind_q != ptlb_pkg::IND_TCLK) |-> !indicator_pin_one;
  endproperty
  a_ind: assert property (p_ind) else $error("pin leaks"); // [RULE5]
  property p_mloop;
    (basic_q[ptlb_pkg::B_MLOOP] && !basic_q[ptlb_pkg::B_ISO] && !gen_on &&
     mac_tx_valid) |=> mac_rx_valid && mac_rx_data == $past(mac_tx_data);
  endproperty
  a_mloop: assert property (p_mloop) else $error("mac loop"); // [RULE6]
  property p_rev;
    (stc_q[ptlb_pkg::B_REV] && !tm_act && line_rx_valid) |=>
      line_tx_valid && line_tx_data == $past(line_rx_data);
  endproperty
  a_rev: assert property (p_rev) else $error("reverse loop"); // [RULE7]
  property p_iso;
    basic_q[ptlb_pkg::B_ISO] |=> !mac_rx_valid;
  endproperty
  a_iso: assert property (p_iso) else $error("isolate fails"); // [RULE9]
  property p_gap;
    (gen_q == ptlb_pkg::GEN_GAP) |-> cnt_q < {3'h0, gap_q, 2'h0};
  endproperty
  a_gap: assert property (p_gap) else $error("gap overrun"); // [RULE10]
  property p_err;
    (mgmt_rd && mgmt_addr == ptlb_pkg::A_GAP && esel_q) |=>
      mgmt_rdata[15:8] == $past(err_q);
  endproperty
  a_err: assert property (p_err) else $error("count unseen"); // [RULE14]
endmodule // ptlb_core
`default_nettype wire

// File: sim/ptlb_line_partner.sv
/*
  Line link partner: sends a counting byte stream when asked.
  Assumes the bench raises send off the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module ptlb_line_partner (
  input wire logic clk_sys,
  input wire logic send,
  output logic [7:0] line_rx_data,
  output logic line_rx_valid
);
  logic send_q;
  logic [7:0] cnt_q;
  initial begin
    send_q = 1'b0;
    cnt_q = 8'h30;
    line_rx_data = 8'h00;
    line_rx_valid = 1'b0;
  end
  // Request sampled on the rising edge, bytes change on the falling edge
  always @(posedge clk_sys) begin
    send_q <= send;
  end
  // Idle data inverts so a stale byte never passes as an echo
  always @(negedge clk_sys) begin
    if (send_q) begin
      line_rx_data <= cnt_q;
      line_rx_valid <= 1'b1;
      cnt_q <= cnt_q + 8'h01;
    end else begin
      line_rx_data <= ~line_rx_data;
      line_rx_valid <= 1'b0;
      cnt_q <= 8'h30; // Every burst starts from the same byte
    end
  end
endmodule // ptlb_line_partner
`default_nettype wire

// File: sim/ptlb_core_bench.sv
/*
  Self-checking bench for the test, loopback and self-test block.
  Assumes the partner model on the line side and straps held steady.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
  num_errors++; $display("[ERR] %0t %s", $time, m); end end
module ptlb_core_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] mgmt_addr = 5'h00;
  logic mgmt_wr = 1'b0;
  logic mgmt_rd = 1'b0;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic [7:0] mac_tx_data = 8'h00;
  logic mac_tx_valid = 1'b0;
  logic [15:0] strap_pins = 16'h5a3c;
  logic send = 1'b0;
  logic [15:0] mgmt_rdata;
  logic [7:0] mac_rx_data, line_rx_data, line_tx_data;
  logic mac_rx_valid, line_rx_valid, line_tx_valid, line_test_active;
  logic transmit_symbol_clock, indicator_pin_one, pc;
  logic [1:0] line_test_sym;
  logic [15:0] rd;
  logic [15:0] tm [4] = '{16'h2000, 16'h4000, 16'h8000, 16'ha000};
  int num_errors = 0;
  int check_count = 0;
  int n, m, mp, mm;
  always #4 clk_sys = ~clk_sys;
  ptlb_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mac_tx_data(mac_tx_data), .mac_tx_valid(mac_tx_valid),
    .mac_rx_data(mac_rx_data), .mac_rx_valid(mac_rx_valid),
    .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
    .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid),
    .line_test_sym(line_test_sym), .line_test_active(line_test_active),
    .transmit_symbol_clock(transmit_symbol_clock),
    .indicator_pin_one(indicator_pin_one), .strap_pins(strap_pins));
  ptlb_line_partner i_line (.clk_sys(clk_sys), .send(send),
    .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid));
  task automatic end_sim;
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Strobes last one cycle; an idle cycle separates accesses
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(negedge clk_sys);
    mgmt_wr = 1'b0;
  endtask
  task automatic rdr(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(negedge clk_sys);
    mgmt_rd = 1'b0;
    @(negedge clk_sys);
    d = mgmt_rdata;
  endtask
  // Indirect access: space, address, space with data function
  task automatic xset(input logic [4:0] sp, input logic [15:0] ra);
    wr(ptlb_pkg::A_MMD_CTL, {11'h000, sp});
    wr(ptlb_pkg::A_MMD_DAT, ra);
    wr(ptlb_pkg::A_MMD_CTL, {11'h200, sp});
  endtask
  // Echo of partner bytes half a cycle later, at the next rising edge; MAC copy unless isolated
  task automatic echo_chk(input logic mac_on);
    logic pv;
    logic [7:0] pd;
    repeat (10) begin
      // Partner bytes settle after the falling edge
      @(negedge clk_sys);
      #1;
      pv = line_rx_valid;
      pd = line_rx_data;
      @(posedge clk_sys);
      #1;
      `CHK(line_tx_valid, pv, "echo valid")
      if (pv) `CHK(line_tx_data, pd, "echo data")
      `CHK(mac_rx_valid, pv & mac_on, "mac copy")
      if (pv & mac_on) `CHK(mac_rx_data, pd, "mac data")
    end
  endtask
  // One MAC byte through a near-end loop, seen after lat edges
  task automatic mloop(input logic [7:0] b, input int lat);
    @(negedge clk_sys);
    mac_tx_data = b;
    mac_tx_valid = 1'b1;
    @(negedge clk_sys);
    mac_tx_valid = 1'b0;
    repeat (lat - 1) begin
      `CHK(mac_rx_valid, 1'b0, "loop early")
      @(negedge clk_sys);
    end
    `CHK(mac_rx_valid, 1'b1, "loop valid")
    `CHK(mac_rx_data, b, "loop data")
    `CHK(line_tx_valid, 1'b0, "loop no line")
  endtask
  // Longest run of +1 and of -1 symbols, in cycles
  task automatic sym_runs(output int bp, output int bm, output int nc);
    int rp, rm;
    logic [1:0] ps;
    rp = 0;
    rm = 0;
    bp = 0;
    bm = 0;
    nc = 0;
    ps = line_test_sym;
    repeat (400) begin
      @(posedge clk_sys);
      #1;
      if (line_test_sym !== ps) nc++;
      ps = line_test_sym;
      rp = (line_test_sym === ptlb_pkg::SYM_P) ? rp + 1 : 0;
      rm = (line_test_sym === ptlb_pkg::SYM_M) ? rm + 1 : 0;
      if (rp > bp) bp = rp;
      if (rm > bm) bm = rm;
    end
  endtask
  // Bounded count of cycles with line_tx_valid at one level
  task automatic run_len(input logic lvl, output int cnt);
    cnt = 0;
    while (line_tx_valid === lvl && cnt < 4000) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    if (cnt >= 4000) begin
      num_errors++;
      $display("[ERR] %0t stuck line valid", $time);
      end_sim();
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    $display("[ERR] %0t timeout", $time);
    end_sim();
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    rdr(ptlb_pkg::A_BASIC, rd);
    `CHK(rd, ptlb_pkg::BASIC_RST, "basic reset")
    rdr(ptlb_pkg::A_GAP, rd);
    `CHK(rd, {8'h00, ptlb_pkg::GAP_RST}, "gap reset")
    rdr(ptlb_pkg::A_LEN, rd);
    `CHK(rd, {5'h00, ptlb_pkg::LEN_RST}, "len reset")
    rdr(5'h05, rd);
    `CHK(rd, 16'h0000, "unmapped read")
    `CHK(indicator_pin_one, 1'b0, "indicator idle")
    // Strap register ignores writes
    xset(ptlb_pkg::SP_VEND, ptlb_pkg::X_STRAP);
    wr(ptlb_pkg::A_MMD_DAT, 16'h0000);
    rdr(ptlb_pkg::A_MMD_DAT, rd);
    `CHK(rd, 16'h5a3c, "strap latch")
    // MAC loop, one byte
    wr(ptlb_pkg::A_BASIC, 16'h6100);
    @(negedge clk_sys);
    mac_tx_data = 8'hab;
    mac_tx_valid = 1'b1;
    @(negedge clk_sys);
    mac_tx_valid = 1'b0;
    `CHK(mac_rx_valid, 1'b1, "mac loop valid")
    `CHK(mac_rx_data, 8'hab, "mac loop data")
    `CHK(line_tx_valid, 1'b0, "mac loop no line")
    // Deeper near-end loops add one edge each
    wr(ptlb_pkg::A_BASIC, 16'h0000);
    wr(ptlb_pkg::A_STC, 16'h0002);
    mloop(8'h5c, 2);
    wr(ptlb_pkg::A_STC, 16'h0004);
    mloop(8'hc5, 3);
    // Reverse loop, then isolate
    wr(ptlb_pkg::A_BASIC, 16'h0000);
    wr(ptlb_pkg::A_STC, 16'h0110);
    send = 1'b1;
    echo_chk(1'b1);
    wr(ptlb_pkg::A_BASIC, 16'h0400);
    echo_chk(1'b0);
    wr(ptlb_pkg::A_BASIC, 16'h0000);
    // Every test mode, while echo traffic still arrives
    for (int i = 0; i < 4; i++) begin
      xset(ptlb_pkg::SP_PMA, ptlb_pkg::X_TEST);
      wr(ptlb_pkg::A_MMD_DAT, tm[i]);
      rdr(ptlb_pkg::A_MMD_DAT, rd);
      `CHK(rd, tm[i], "mode readback")
      `CHK(line_test_active, 1'b1, "mode active")
      `CHK(line_tx_valid, 1'b0, "mode owns line")
      sym_runs(mp, mm, n);
      // Mode 2 changes symbol on every strobe: 213 or 214 in 400
      if (i == 1) `CHK(n >= 212 && n <= 215, 1'b1, "symbol rate")
      if (i == 0) `CHK(mp >= 74 && mm >= 74, 1'b1, "mode 1 runs")
      if (i == 1) `CHK(mp <= 2 && mm <= 2 && mp > 0 && mm > 0, 1'b1,
        "mode 2 tone")
    end
    wr(ptlb_pkg::A_MMD_DAT, 16'h0000);
    repeat (3) @(negedge clk_sys);
    `CHK(line_test_active, 1'b0, "mode off")
    echo_chk(1'b1);
    send = 1'b0;
    // Symbol clock on the indicator
    xset(ptlb_pkg::SP_VEND, ptlb_pkg::X_IND);
    wr(ptlb_pkg::A_MMD_DAT, ptlb_pkg::IND_TCLK);
    m = 0;
    n = 0;
    pc = 1'b1;
    repeat (375) begin
      @(posedge clk_sys);
      #1;
      if (indicator_pin_one !== transmit_symbol_clock) m++;
      if (transmit_symbol_clock === 1'b1 && pc === 1'b0) n++;
      pc = transmit_symbol_clock;
    end
    `CHK(m, 0, "indicator follows clock")
    // Sampled at 125 MHz the clock aliases to 58.3 MHz: 175 rises
    `CHK(n >= 173 && n <= 177, 1'b1, "clock edges")
    // Generator: 16-byte packets, gap of 2 units is 8 bytes
    wr(ptlb_pkg::A_STC, 16'h0000);
    wr(ptlb_pkg::A_GAP, 16'h0002);
    wr(ptlb_pkg::A_LEN, 16'h0010);
    wr(ptlb_pkg::A_STC, 16'h7100);
    @(posedge clk_sys);
    #1;
    run_len(1'b0, n);
    run_len(1'b1, n);
    run_len(1'b0, n);
    `CHK(n, 8, "gap bytes")
    run_len(1'b1, n);
    `CHK(n, 16, "packet bytes")
    wr(ptlb_pkg::A_GAP, 16'h8002);
    rdr(ptlb_pkg::A_GAP, rd);
    `CHK(rd[7:0], 8'h02, "gap kept")
    m = int'(rd[15:8]);
    rdr(ptlb_pkg::A_STC, rd);
    `CHK(rd[15:12], 4'h7, "control kept")
    `CHK(rd[ptlb_pkg::ST_HI], m != 0, "error status")
    // Partner bytes start at 0x30, so every checked byte is wrong
    send = 1'b1;
    repeat (300) @(negedge clk_sys);
    send = 1'b0;
    rdr(ptlb_pkg::A_GAP, rd);
    `CHK(rd[15:8], 8'hff, "error count")
    rdr(ptlb_pkg::A_STC, rd);
    `CHK(rd[ptlb_pkg::ST_HI:ptlb_pkg::ST_LO+1], 2'b11, "chk stat")
    end_sim();
  end
endmodule // ptlb_core_bench
`default_nettype wire
